//--- ulf_pkg.sv
package ulf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] ULF_FCTL_ADDR = 32'h4000_8008;
    localparam logic [31:0] ULF_LFMT_ADDR = 32'h4000_800c;
    // Only the low byte of the address is decoded
    localparam logic [7:0] ULF_OFF_FCTL = ULF_FCTL_ADDR[7:0];
    localparam logic [7:0] ULF_OFF_LFMT = ULF_LFMT_ADDR[7:0];
    localparam logic [7:0] ULF_OFF_ISTS = 8'h10;
    localparam logic [7:0] ULF_OFF_IMSK = 8'h14;
    localparam logic [7:0] ULF_OFF_STAT = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ULF_FC_EN = 0;
    localparam int ULF_FC_RXFL = 1;
    localparam int ULF_FC_TXFL = 2;
    localparam int ULF_FC_TRIG_LO = 6;
    localparam int ULF_LF_WLS_LO = 0;
    localparam int ULF_LF_STOP = 2;
    localparam int ULF_LF_PEN = 3;
    localparam int ULF_LF_PTYPE_LO = 4;
    localparam int ULF_LF_BREAK = 6;
    localparam int ULF_LF_DIV = 7;
    localparam int ULF_IRQ_RDA = 0;
    localparam int ULF_IRQ_ENCHG = 1;

    // ------------------------------------------------------------
    // Encodings and values
    // ------------------------------------------------------------
    localparam logic [4:0] ULF_TRIG_L0 = 5'h01;
    localparam logic [4:0] ULF_TRIG_L1 = 5'h04;
    localparam logic [4:0] ULF_TRIG_L2 = 5'h08;
    localparam logic [4:0] ULF_TRIG_L3 = 5'h0e;
    localparam logic [3:0] ULF_WLS_BASE = 4'h5;
    localparam logic [2:0] ULF_STOP_ONE = 3'h2;
    localparam logic [2:0] ULF_STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] ULF_STOP_TWO = 3'h4;
    localparam logic [1:0] ULF_RESP_OKAY = 2'h0;
    localparam logic [1:0] ULF_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ULF_PAR_ODD = 2'b00,
        ULF_PAR_EVEN = 2'b01,
        ULF_PAR_ONE = 2'b10,
        ULF_PAR_ZERO = 2'b11
    } ulf_par_t;

    // ------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic fifo_en;
        logic [1:0] trig;
        logic rx_flush;
        logic tx_flush;
        logic [7:0] lfmt;
        logic [1:0] irq_sts;
        logic [1:0] irq_msk;
        logic receive_data_available_irq;
        logic irq;
        logic txd;
    } ulf_state_t;

    localparam ulf_state_t ULF_RST = '{txd: 1'b1, default: '0};

    typedef struct packed {
        logic [3:0] char_bits;
        logic [2:0] stop_halves;
        logic tx_par;
        logic rx_err;
    } ulf_fmt_state_t;

endpackage

//--- ulf_fmt_if.sv
`timescale 1ns/100ps
interface ulf_fmt_if;
    logic [1:0] word_length_select;
    logic stop_sel;
    logic par_en;
    logic [1:0] par_type;
    logic [7:0] tx_char;
    logic [7:0] rx_char;
    logic rx_par_bit;
    logic [3:0] char_bits;
    logic [2:0] stop_halves;
    logic tx_par;
    logic rx_err;

    modport ctl (
        output word_length_select, stop_sel, par_en, par_type, tx_char, rx_char, rx_par_bit,
        input char_bits, stop_halves, tx_par, rx_err
    );
    modport fmt (
        input word_length_select, stop_sel, par_en, par_type, tx_char, rx_char, rx_par_bit,
        output char_bits, stop_halves, tx_par, rx_err
    );
endinterface

//--- ulf_fmt.sv
`timescale 1ns/100ps
module ulf_fmt (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Format link to the control block
    ulf_fmt_if.fmt f
);

    ulf_pkg::ulf_fmt_state_t s_r;
    ulf_pkg::ulf_fmt_state_t s_nxt;
    logic [7:0] mask;
    logic tx_ones;
    logic rx_ones;

    // ------------------------------------------------------------
    // Character format decode and parity
    // ------------------------------------------------------------
    always_comb begin
        mask = 8'hff >> (2'd3 - f.word_length_select);
        tx_ones = ^(f.tx_char & mask);
        rx_ones = ^(f.rx_char & mask);
        s_nxt = s_r;
        s_nxt.char_bits = ulf_pkg::ULF_WLS_BASE + {2'b00, f.word_length_select};
        // Five-bit characters shorten the long stop to one and a half
        if (!f.stop_sel) begin
            s_nxt.stop_halves = ulf_pkg::ULF_STOP_ONE;
        end else if (f.word_length_select == 2'b00) begin
            s_nxt.stop_halves = ulf_pkg::ULF_STOP_ONE_HALF;
        end else begin
            s_nxt.stop_halves = ulf_pkg::ULF_STOP_TWO;
        end
        case (f.par_type)
            ulf_pkg::ULF_PAR_ODD: s_nxt.tx_par = ~tx_ones;
            ulf_pkg::ULF_PAR_EVEN: s_nxt.tx_par = tx_ones;
            ulf_pkg::ULF_PAR_ONE: s_nxt.tx_par = 1'b1;
            ulf_pkg::ULF_PAR_ZERO: s_nxt.tx_par = 1'b0;
            default: s_nxt.tx_par = 1'b0;
        endcase
        // Receive check only runs with parity enabled
        case (f.par_type)
            ulf_pkg::ULF_PAR_ODD: s_nxt.rx_err = ~(rx_ones ^ f.rx_par_bit);
            ulf_pkg::ULF_PAR_EVEN: s_nxt.rx_err = rx_ones ^ f.rx_par_bit;
            ulf_pkg::ULF_PAR_ONE: s_nxt.rx_err = ~f.rx_par_bit;
            ulf_pkg::ULF_PAR_ZERO: s_nxt.rx_err = f.rx_par_bit;
            default: s_nxt.rx_err = 1'b0;
        endcase
        s_nxt.rx_err = s_nxt.rx_err & f.par_en;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign f.char_bits = s_r.char_bits;
    assign f.stop_halves = s_r.stop_halves;
    assign f.tx_par = s_r.tx_par;
    assign f.rx_err = s_r.rx_err;

endmodule

//--- ulf_ctl.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Enable bit 0 at 1 turns on both FIFOs and admits the upper control bits.
// - Any change of the enable bit flushes both FIFOs.
// - Writing 1 to the receive flush bit with enable 1 empties the receive FIFO once.
// - Writing 1 to the transmit flush bit with enable 1 empties the transmit FIFO once.
// - Writing 0 to a flush bit leaves its FIFO alone unless the same write changes the enable bit.
// - The FIFO control register cannot be read back; it reads zero.
// - Trigger field selects 1, 4, 8 or 14 characters.
// - Word length field selects 5, 6, 7 or 8 data bits.
// - Parity enable adds parity on transmit and checks it on receive.
// - Parity type: odd, even, forced one, forced zero.
// - Break bit holds the serial output low.
// - Divisor gate bit opens access to the baud divisor latches.
// - Data-available interrupt is high while fill is at or above trigger.
module ulf_ctl (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // AXI4-Lite write address and data
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // FIFO side
    input wire logic [4:0] RX_FILL,
    output logic FIFO_ENABLE,
    output logic RX_FLUSH,
    output logic TX_FLUSH,
    output logic RDA_IRQ,
    // Serial line and character path
    input wire logic TX_SERIAL,
    output logic TXD,
    input wire logic [7:0] TX_CHAR,
    input wire logic [7:0] RX_CHAR,
    input wire logic RX_PAR_BIT,
    // Character format
    output logic [3:0] WORD_BITS,
    output logic [2:0] STOP_HALVES,
    output logic PARITY_ENABLE,
    output logic TX_PARITY_BIT,
    output logic RX_PARITY_ERR,
    output logic DIV_ACCESS,
    // Interrupt
    output logic IRQ
);

    ulf_pkg::ulf_state_t s_r;
    ulf_pkg::ulf_state_t s_nxt;
    ulf_fmt_if fmt_if ();
    logic [4:0] trig_count;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic wr_fire;
    logic [7:0] wb;

    // ------------------------------------------------------------
    // Format and parity helper
    // ------------------------------------------------------------
    assign fmt_if.word_length_select = s_r.lfmt[ulf_pkg::ULF_LF_WLS_LO +: 2];
    assign fmt_if.stop_sel = s_r.lfmt[ulf_pkg::ULF_LF_STOP];
    assign fmt_if.par_en = s_r.lfmt[ulf_pkg::ULF_LF_PEN];
    assign fmt_if.par_type = s_r.lfmt[ulf_pkg::ULF_LF_PTYPE_LO +: 2];
    assign fmt_if.tx_char = TX_CHAR;
    assign fmt_if.rx_char = RX_CHAR;
    assign fmt_if.rx_par_bit = RX_PAR_BIT;

    ulf_fmt u_fmt (
        .clk(CORE_CLK),
        .nrst(NRST),
        .f(fmt_if.fmt)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        irq_set = 2'b00;
        irq_clr = 2'b00;
        wb = s_r.w_byte;
        wr_fire = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
        // Flush strobes are one cycle long: the bits clear themselves
        s_nxt.rx_flush = 1'b0;
        s_nxt.tx_flush = 1'b0;

        // Address and data are taken independently, in either order
        if (AWVALID && s_r.awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.aw_addr = AWADDR[7:0];
        end
        if (WVALID && s_r.wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.w_byte = WDATA[7:0];
            s_nxt.w_lane0 = WSTRB[0];
        end
        if (s_r.bvalid && BREADY) begin
            s_nxt.bvalid = 1'b0;
        end

        // Write commit once both halves are held
        if (wr_fire) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = ulf_pkg::ULF_RESP_OKAY;
            case (s_r.aw_addr)
                ulf_pkg::ULF_OFF_FCTL: begin
                    if (s_r.w_lane0) begin
                        // A toggle of the enable empties both FIFOs
                        if (wb[ulf_pkg::ULF_FC_EN] != s_r.fifo_en) begin
                            s_nxt.rx_flush = 1'b1;
                            s_nxt.tx_flush = 1'b1;
                            irq_set[ulf_pkg::ULF_IRQ_ENCHG] = 1'b1;
                        end
                        s_nxt.fifo_en = wb[ulf_pkg::ULF_FC_EN];
                        // Upper bits only count when this write enables
                        if (wb[ulf_pkg::ULF_FC_EN]) begin
                            s_nxt.trig = wb[ulf_pkg::ULF_FC_TRIG_LO +: 2];
                            // A zero leaves the FIFO untouched
                            if (wb[ulf_pkg::ULF_FC_RXFL]) begin
                                s_nxt.rx_flush = 1'b1;
                            end
                            if (wb[ulf_pkg::ULF_FC_TXFL]) begin
                                s_nxt.tx_flush = 1'b1;
                            end
                        end
                    end
                end
                ulf_pkg::ULF_OFF_LFMT: begin
                    if (s_r.w_lane0) begin
                        s_nxt.lfmt = wb;
                    end
                end
                ulf_pkg::ULF_OFF_ISTS: begin
                    if (s_r.w_lane0) begin
                        irq_clr = wb[1:0];
                    end
                end
                ulf_pkg::ULF_OFF_IMSK: begin
                    if (s_r.w_lane0) begin
                        s_nxt.irq_msk = wb[1:0];
                    end
                end
                ulf_pkg::ULF_OFF_STAT: begin
                    s_nxt.bresp = ulf_pkg::ULF_RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = ulf_pkg::ULF_RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one read at a time, answered next cycle
        if (s_r.rvalid && RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ARVALID && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = ulf_pkg::ULF_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (ARADDR[7:0])
                ulf_pkg::ULF_OFF_FCTL: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
                ulf_pkg::ULF_OFF_LFMT: begin
                    s_nxt.rdata = {24'h00_0000, s_r.lfmt};
                end
                ulf_pkg::ULF_OFF_ISTS: begin
                    s_nxt.rdata = {30'h0000_0000, s_r.irq_sts};
                end
                ulf_pkg::ULF_OFF_IMSK: begin
                    s_nxt.rdata = {30'h0000_0000, s_r.irq_msk};
                end
                ulf_pkg::ULF_OFF_STAT: begin
                    s_nxt.rdata = {19'h0_0000, RX_FILL, 4'h0,
                                   s_r.receive_data_available_irq, s_r.trig, s_r.fifo_en};
                end
                default: begin
                    s_nxt.rresp = ulf_pkg::ULF_RESP_SLVERR;
                end
            endcase
        end

        // Data-available level follows fill against the trigger
        case (s_r.trig)
            2'b00: trig_count = ulf_pkg::ULF_TRIG_L0;
            2'b01: trig_count = ulf_pkg::ULF_TRIG_L1;
            2'b10: trig_count = ulf_pkg::ULF_TRIG_L2;
            2'b11: trig_count = ulf_pkg::ULF_TRIG_L3;
            default: trig_count = ulf_pkg::ULF_TRIG_L0;
        endcase
        s_nxt.receive_data_available_irq = (RX_FILL >= trig_count);
        irq_set[ulf_pkg::ULF_IRQ_RDA] = s_nxt.receive_data_available_irq && !s_r.receive_data_available_irq;

        // Sticky status: a new event beats a same-cycle clear
        s_nxt.irq_sts = (s_r.irq_sts & ~irq_clr) | irq_set;
        s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);

        // Break overrides whatever the transmitter shifts out
        s_nxt.txd = s_r.lfmt[ulf_pkg::ULF_LF_BREAK] ? 1'b0 : TX_SERIAL;

        // Ready flags are registered from the state they will see
        s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
    end

    // State register; fields start at zero, line idles high
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            s_r <= ulf_pkg::ULF_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AWREADY = s_r.awready;
    assign WREADY = s_r.wready;
    assign ARREADY = s_r.arready;
    assign BVALID = s_r.bvalid;
    assign BRESP = s_r.bresp;
    assign RVALID = s_r.rvalid;
    assign RDATA = s_r.rdata;
    assign RRESP = s_r.rresp;
    assign FIFO_ENABLE = s_r.fifo_en;
    assign RX_FLUSH = s_r.rx_flush;
    assign TX_FLUSH = s_r.tx_flush;
    assign RDA_IRQ = s_r.receive_data_available_irq;
    assign TXD = s_r.txd;
    assign WORD_BITS = fmt_if.char_bits;
    assign STOP_HALVES = fmt_if.stop_halves;
    assign PARITY_ENABLE = s_r.lfmt[ulf_pkg::ULF_LF_PEN];
    assign TX_PARITY_BIT = fmt_if.tx_par;
    assign RX_PARITY_ERR = fmt_if.rx_err;
    assign DIV_ACCESS = s_r.lfmt[ulf_pkg::ULF_LF_DIV];
    assign IRQ = s_r.irq;

endmodule

//--- ulf_properties.sv
`timescale 1ns/100ps
module ulf_properties (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Write response
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    // FIFO side and format outputs
    input wire logic [4:0] RX_FILL,
    input wire logic FIFO_ENABLE,
    input wire logic RX_FLUSH,
    input wire logic TX_FLUSH,
    input wire logic RDA_IRQ,
    input wire logic [3:0] WORD_BITS,
    input wire logic [2:0] STOP_HALVES,
    input wire logic PARITY_ENABLE,
    input wire logic RX_PARITY_ERR
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    // Any move of the enable bit empties both FIFOs
    a_enable_flush: assert property (
        $changed(FIFO_ENABLE) |-> RX_FLUSH && TX_FLUSH)
        else $error("Enable change without both flushes");
    // Flushes are one-cycle pulses launched only by a register write
    a_flush_pulse: assert property (
        RX_FLUSH || TX_FLUSH |-> $rose(BVALID) ##1 !(RX_FLUSH || TX_FLUSH))
        else $error("Flush pulse outside a write or too long");
    // Every trigger level is at least one character
    a_rda_empty: assert property (
        RX_FILL == 5'h00 |=> !RDA_IRQ)
        else $error("Data available with empty FIFO");
    // Every trigger level is at most fourteen characters
    a_rda_full: assert property (
        RX_FILL >= 5'h0e |=> RDA_IRQ)
        else $error("No data available at fourteen characters");
    // First edge after release still shows the reset value, so skip it
    a_word_range: assert property (
        $past(NRST) |-> WORD_BITS >= 4'h5 && WORD_BITS <= 4'h8)
        else $error("Word length outside five to eight");
    a_stop_code: assert property (
        $past(NRST) |-> STOP_HALVES == 3'h2 || STOP_HALVES == 3'h4
            || STOP_HALVES == 3'h3 && WORD_BITS == 4'h5)
        else $error("Stop length illegal for word length");
    a_parity_off: assert property (
        !PARITY_ENABLE ##1 !PARITY_ENABLE |-> !RX_PARITY_ERR)
        else $error("Parity error with parity disabled");
    a_resp_hold: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("Write response dropped before taken");
endmodule

bind ulf_ctl ulf_properties u_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .RX_FILL(RX_FILL),
    .FIFO_ENABLE(FIFO_ENABLE), .RX_FLUSH(RX_FLUSH), .TX_FLUSH(TX_FLUSH),
    .RDA_IRQ(RDA_IRQ), .WORD_BITS(WORD_BITS), .STOP_HALVES(STOP_HALVES),
    .PARITY_ENABLE(PARITY_ENABLE), .RX_PARITY_ERR(RX_PARITY_ERR));

//--- ulf_peer.sv
`timescale 1ns/100ps
module ulf_peer (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Character arrival and flush
    input wire logic push,
    input wire logic rx_flush,
    // Fill count and serial bit
    output logic [4:0] rx_fill,
    output logic tx_serial
);
    // Flush wins over an arrival in the same cycle; fill stops at 16
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_fill <= 5'h00;
            tx_serial <= 1'b1;
        end else begin
            tx_serial <= ~tx_serial;
            if (rx_flush) begin
                rx_fill <= 5'h00;
            end else if (push && rx_fill < 5'h10) begin
                rx_fill <= rx_fill + 5'h01;
            end
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
    // ----
    // Signals and bench model
    // ----
    logic CORE_CLK = 1'b0, NRST = 1'b0, push = 1'b0, RX_PAR_BIT = 1'b0;
    logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0, RDATA;
    logic [3:0] WSTRB = '0, WORD_BITS;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0, AWREADY, WREADY, BVALID, ARREADY;
    logic RVALID, FIFO_ENABLE, RX_FLUSH, TX_FLUSH, RDA_IRQ, TX_SERIAL, TXD;
    logic PARITY_ENABLE, TX_PARITY_BIT, RX_PARITY_ERR, DIV_ACCESS, IRQ;
    logic [1:0] BRESP, RRESP, trig;
    logic [4:0] RX_FILL;
    logic [2:0] STOP_HALVES;
    logic [7:0] TX_CHAR = '0, RX_CHAR = '0, v;
    logic fen, ts;
    logic [7:0] ftab [11] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h01, 8'h41,
        8'h81, 8'hc1, 8'hc6, 8'hc6, 8'h01}; // bits 5:4 kept zero
    int num_errors = 0, cmp_count = 0, rx_fl_n = 0, tx_fl_n = 0, i, f;
    int seed = 32'he5582671;

    ulf_ctl DUT (.CORE_CLK(CORE_CLK), .NRST(NRST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .RX_FILL(RX_FILL), .FIFO_ENABLE(FIFO_ENABLE),
        .RX_FLUSH(RX_FLUSH), .TX_FLUSH(TX_FLUSH), .RDA_IRQ(RDA_IRQ),
        .TX_SERIAL(TX_SERIAL), .TXD(TXD), .TX_CHAR(TX_CHAR),
        .RX_CHAR(RX_CHAR), .RX_PAR_BIT(RX_PAR_BIT), .WORD_BITS(WORD_BITS),
        .STOP_HALVES(STOP_HALVES), .PARITY_ENABLE(PARITY_ENABLE),
        .TX_PARITY_BIT(TX_PARITY_BIT), .RX_PARITY_ERR(RX_PARITY_ERR),
        .DIV_ACCESS(DIV_ACCESS), .IRQ(IRQ));
    ulf_peer u_peer (.clk(CORE_CLK), .nrst(NRST), .push(push),
        .rx_flush(RX_FLUSH), .rx_fill(RX_FILL), .tx_serial(TX_SERIAL));

    // 40 MHz clock
    initial forever #12.5 CORE_CLK = ~CORE_CLK;
    // Pulses counted at mid-cycle where outputs are settled
    always @(negedge CORE_CLK) begin
        if (RX_FLUSH === 1'b1) rx_fl_n++;
        if (TX_FLUSH === 1'b1) tx_fl_n++;
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] g, e, input string m);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic par(input logic [7:0] c, fm);
        logic x;
        x = ^(c & (8'hff >> (3 - fm[1:0]))); // Bits above length ignored
        case (fm[5:4])
            2'h0: par = !x;
            2'h1: par = x;
            2'h2: par = 1'b1;
            default: par = 1'b0;
        endcase
    endfunction
    // One write (rw=1) or read; ready raised at random to stall the answer
    task automatic bus(input logic rw, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        int n;
        logic aw, w, ar, got;
        logic [1:0] rsp;
        logic [31:0] rdv;
        n = 0;
        got = 1'b0;
        if (rw) begin
            AWADDR <= {24'h400080, a};
            WDATA <= d;
            WSTRB <= s;
            AWVALID <= 1'b1;
            WVALID <= 1'b1;
        end else begin
            ARADDR <= {24'h400080, a};
            ARVALID <= 1'b1;
        end
        while (!got) begin
            @(negedge CORE_CLK);
            aw = AWVALID && AWREADY;
            w = WVALID && WREADY;
            ar = ARVALID && ARREADY;
            got = rw ? BVALID && BREADY : RVALID && RREADY;
            rsp = rw ? BRESP : RRESP;
            rdv = RDATA;
            @(posedge CORE_CLK);
            if (aw) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
            if (ar) ARVALID <= 1'b0;
            if (rw) BREADY <= !got && (BREADY || $random(seed) & 1);
            else RREADY <= !got && (RREADY || $random(seed) & 1);
            n++;
            if (n > 60) begin
                num_errors++;
                test_done();
            end
        end
        chk(rsp, er, "response");
        if (!rw) chk(rdv, d, "read data");
    endtask
    // Write the FIFO control register and predict flushes and status
    task automatic fctl(input logic [7:0] d);
        int erx, etx;
        erx = rx_fl_n + (d[0] != fen || d[0] && d[1]);
        etx = tx_fl_n + (d[0] != fen || d[0] && d[2]);
        if (d[0]) trig = d[7:6];
        fen = d[0];
        bus(1'b1, 8'h08, {24'h0, d}, 4'h1, 2'h0);
        repeat (2) @(negedge CORE_CLK);
        chk(rx_fl_n, erx, "rx flush");
        chk(tx_fl_n, etx, "tx flush");
        chk(FIFO_ENABLE, fen, "enable");
        @(posedge CORE_CLK);
        bus(1'b0, 8'h18, {29'h0, trig, fen}, 4'h0, 2'h0);
    endtask
    task automatic push1(input logic e);
        push <= 1'b1;
        @(posedge CORE_CLK);
        push <= 1'b0;
        repeat (2) @(negedge CORE_CLK);
        chk(RDA_IRQ, e, "data available");
        @(posedge CORE_CLK);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(negedge CORE_CLK);
        chk(IRQ, e, "interrupt");
        @(posedge CORE_CLK);
    endtask
    task automatic rst();
        NRST <= 1'b0;
        repeat (12) @(posedge CORE_CLK);
        NRST <= 1'b1;
        fen = 1'b0;
        trig = 2'h0;
        repeat (2) @(negedge CORE_CLK);
        chk(WORD_BITS, 4'h5, "reset length");
        chk(STOP_HALVES, 3'h2, "reset stop");
        chk({FIFO_ENABLE, PARITY_ENABLE, DIV_ACCESS}, 0, "flags");
        @(posedge CORE_CLK);
        bus(1'b0, 8'h0c, 32'h0, 4'h0, 2'h0);
        bus(1'b0, 8'h18, 32'h0, 4'h0, 2'h0);
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        rst();
        $display("Test reset done, errors %0d", num_errors);
        // Every length, stop, parity combination; break and gate random
        for (i = 0; i < 64; i++) begin
            v = $random(seed);
            v[5:0] = i[5:0];
            TX_CHAR <= $random(seed);
            RX_CHAR <= $random(seed);
            RX_PAR_BIT <= $random(seed);
            bus(1'b1, 8'h0c, {24'h0, v}, 4'hf, 2'h0);
            repeat (2) @(negedge CORE_CLK);
            chk(WORD_BITS, 4'h5 + v[1:0], "length");
            chk(STOP_HALVES, !v[2] ? 2 : v[1:0] == 0 ? 3 : 4,
                "stop");
            chk(PARITY_ENABLE, v[3], "parity on");
            chk(DIV_ACCESS, v[7], "divisor gate");
            if (v[3]) chk(TX_PARITY_BIT, par(TX_CHAR, v), "tx par");
            chk(RX_PARITY_ERR, v[3] && RX_PAR_BIT != par(RX_CHAR, v),
                "rx parity error");
            ts = TX_SERIAL;
            @(negedge CORE_CLK);
            chk(TXD, v[6] ? 1'b0 : ts, "serial out");
            @(posedge CORE_CLK);
            bus(1'b0, 8'h0c, {24'h0, v}, 4'h0, 2'h0);
        end
        $display("Test format done, errors %0d", num_errors);
        // Refused and read-only accesses
        bus(1'b1, 8'h0c, 32'hff, 4'h0, 2'h0);
        bus(1'b0, 8'h0c, {24'h0, v}, 4'h0, 2'h0);
        bus(1'b1, 8'h20, 32'h1, 4'hf, 2'h2);
        bus(1'b0, 8'h20, 32'h0, 4'h0, 2'h2);
        bus(1'b1, 8'h18, 32'h1, 4'hf, 2'h0);
        bus(1'b0, 8'h08, 32'h0, 4'h0, 2'h0);
        $display("Test refusals done, errors %0d", num_errors);
        foreach (ftab[k]) fctl(ftab[k]);
        $display("Test fifo control done, errors %0d", num_errors);
        for (i = 0; i < 4; i++) begin
            fctl({i[1:0], 6'h03});
            for (f = 1; f <= 16; f++) begin
                push1(f >= (i == 0 ? 1 : i == 1 ? 4 :
                    i == 2 ? 8 : 14));
            end
        end
        fctl(8'h03); // flush drops fill below level
        $display("Test trigger done, errors %0d", num_errors);
        // Raise and clear both events; mask the data-available one
        bus(1'b1, 8'h10, 32'h3, 4'hf, 2'h0);
        bus(1'b1, 8'h14, 32'h1, 4'hf, 2'h0);
        bus(1'b0, 8'h14, 32'h1, 4'h0, 2'h0);
        push1(1'b1);
        irq_is(1'b1);
        bus(1'b0, 8'h10, 32'h1, 4'h0, 2'h0);
        bus(1'b1, 8'h14, 32'h0, 4'hf, 2'h0);
        irq_is(1'b0);
        bus(1'b1, 8'h10, 32'h1, 4'hf, 2'h0);
        bus(1'b1, 8'h14, 32'h3, 4'hf, 2'h0);
        irq_is(1'b0);
        fctl(8'h00);
        irq_is(1'b1);
        bus(1'b0, 8'h10, 32'h2, 4'h0, 2'h0);
        bus(1'b1, 8'h10, 32'h2, 4'hf, 2'h0);
        irq_is(1'b0);
        fctl(8'h01); // left enabled
        $display("Test interrupt done, errors %0d", num_errors);
        rst();
        $display("Test second reset done, errors %0d", num_errors);
        test_done();
    end
endmodule
